// ===== pkg/mcuix_pkg.sv
// Shared constants and types for the instruction subset executor
package mcuix_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PC_W = 16;
  localparam int JUMP_W = 13;
  localparam int PHASES = 4;
  localparam logic [15:0] WDCLR_CODE = 16'h0004;
  localparam logic [6:0] COMPLEMENT_FILE_OP_TOP = 7'h09;
  localparam logic [7:0] CMPLT_TOP = 8'h30;
  localparam logic [6:0] DAJ_TOP = 7'h17;
  localparam logic [6:0] DEC_TOP = 7'h03;
  localparam logic [6:0] DSZ_TOP = 7'h0b;
  localparam logic [6:0] DSNZ_TOP = 7'h13;
  localparam logic [2:0] JMP_TOP = 3'h6;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;

  typedef enum logic [1:0] {
    MCUIX_Q1 = 2'b00,
    MCUIX_Q2 = 2'b01,
    MCUIX_Q3 = 2'b11,
    MCUIX_Q4 = 2'b10
  } mcuix_phase_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_WDCLR, OP_COMPLEMENT_FILE_OP, OP_CMPLT, OP_DAJ,
    OP_DEC, OP_DSZ, OP_DSNZ, OP_JMP
  } mcuix_op_t;

  typedef struct packed {
    mcuix_op_t op;
    logic dest;
    logic [ADDR_W-1:0] addr;
    logic [JUMP_W-1:0] lit;
  } mcuix_dec_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mcuix_wr_t;
endpackage

// ===== rtl/mcuix_decoder.sv
// Opcode decoder for the supported instruction subset
`timescale 1ns/1ps
module mcuix_decoder (
  input wire logic [15:0] instr,
  output mcuix_pkg::mcuix_dec_t dec
);
  import mcuix_pkg::*;

  always_comb begin
    dec.dest = instr[8];
    dec.addr = instr[7:0];
    dec.lit = instr[JUMP_W-1:0];
    dec.op = OP_NONE;
    if (instr == WDCLR_CODE) begin
      dec.op = OP_WDCLR;
    end else if (instr[15:9] == COMPLEMENT_FILE_OP_TOP) begin
      dec.op = OP_COMPLEMENT_FILE_OP;
    end else if (instr[15:8] == CMPLT_TOP) begin
      dec.op = OP_CMPLT;
    end else if (instr[15:9] == DAJ_TOP) begin
      dec.op = OP_DAJ;
    end else if (instr[15:9] == DEC_TOP) begin
      dec.op = OP_DEC;
    end else if (instr[15:9] == DSZ_TOP) begin
      dec.op = OP_DSZ;
    end else if (instr[15:9] == DSNZ_TOP) begin
      dec.op = OP_DSNZ;
    end else if (instr[15:13] == JMP_TOP) begin
      dec.op = OP_JMP;
    end
  end
endmodule

// ===== rtl/mcuix_core.sv
// Four-phase executor for a subset of core instructions
`timescale 1ns/1ps
// What this block does
// - Watchdog clear zeroes counter, postscaler, sets flags
// - Watchdog clear fixed opcode, one cycle, no write
// - Complement inverts file, zero flag, Q4 write
// - Destination bit: 0 accumulator, 1 file; adjust writes the file for both
// - Compare subtracts unsigned, no flags, no store
// - File below accumulator skips next as no-op
// - Decimal adjust low nibble plus six when above nine or digit carry set
// - Adjust result to file, accumulator if select 0
// - Decrement skip nonzero, flags untouched, two cycles when the skip is taken, else one
// - Instruction cycle is four clock phases
module mcuix_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] instrWord,
  input wire logic [mcuix_pkg::DATA_W-1:0] fileRdData,
  output logic [mcuix_pkg::ADDR_W-1:0] fileRdAddr,
  output mcuix_pkg::mcuix_wr_t fileWr,
  output logic [mcuix_pkg::PC_W-1:0] progCounter,
  output logic [7:0] programCounterHighLatch,
  output logic [mcuix_pkg::DATA_W-1:0] workingAccumulator,
  output logic [3:0] arithFlagsReg,
  output logic timeoutFlag,
  output logic powerdownFlag,
  output logic [7:0] watchdogCounter,
  output logic watchdogPostscaler,
  output logic fetchStrobe
);
  import mcuix_pkg::*;

  mcuix_phase_t phase_reg;
  mcuix_dec_t decoded;
  mcuix_dec_t cur_reg;
  logic [15:0] instr_reg;
  logic squash_reg;
  logic [DATA_W-1:0] operand_reg;
  logic [DATA_W-1:0] result_reg;
  logic skipNext;
  logic [DATA_W-1:0] decRes;
  logic [DATA_W:0] decWide;
  logic [3:0] lowAdj;
  logic [4:0] highAdj;
  logic lowFix;
  logic highFix;

  mcuix_decoder u_dec (
    .instr(instr_reg),
    .dec(decoded)
  );

  // One phase per clock; Q1 latches decode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_reg <= MCUIX_Q1;
    end else begin
      unique case (phase_reg)
        MCUIX_Q1: phase_reg <= MCUIX_Q2;
        MCUIX_Q2: phase_reg <= MCUIX_Q3;
        MCUIX_Q3: phase_reg <= MCUIX_Q4;
        MCUIX_Q4: phase_reg <= MCUIX_Q1;
      endcase
    end
  end

  // Prefetch: the word present at Q4 is next cycle's instruction
  assign fetchStrobe = (phase_reg == MCUIX_Q4);
  assign fileRdAddr = cur_reg.addr;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      instr_reg <= 16'h0000;
    end else if (phase_reg == MCUIX_Q4) begin
      instr_reg <= instrWord;
    end
  end

  // Squashed cycle executes as a forced no-op
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_reg <= '0;
    end else if (phase_reg == MCUIX_Q1) begin
      cur_reg <= decoded;
      if (squash_reg) begin
        cur_reg.op <= OP_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      operand_reg <= ZERO;
    end else if (phase_reg == MCUIX_Q2) begin
      operand_reg <= fileRdData;
    end
  end

  assign decWide = {1'b0, operand_reg} - {1'b0, ONE};
  assign decRes = decWide[DATA_W-1:0];
  assign lowFix = (workingAccumulator[3:0] > BCD_LIMIT) ||
                  arithFlagsReg[FLAG_DC];
  assign lowAdj = workingAccumulator[3:0] + (lowFix ? BCD_FIX : 4'h0);
  assign highFix = (workingAccumulator[7:4] > BCD_LIMIT) ||
                   arithFlagsReg[FLAG_C];
  assign highAdj = {1'b0, workingAccumulator[7:4]} +
                   {1'b0, (highFix ? BCD_FIX : 4'h0)};

  always_comb begin
    skipNext = 1'b0;
    unique case (cur_reg.op)
      OP_CMPLT: skipNext = operand_reg < workingAccumulator;
      OP_DSZ: skipNext = (decRes == ZERO);
      OP_DSNZ: skipNext = (decRes != ZERO);
      OP_JMP: skipNext = 1'b1;
      default: skipNext = 1'b0;
    endcase
  end

  // Q3 execute: result and skip decision
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_reg <= ZERO;
    end else if (phase_reg == MCUIX_Q3) begin
      unique case (cur_reg.op)
        OP_COMPLEMENT_FILE_OP: result_reg <= ~operand_reg;
        OP_DAJ: result_reg <= {highAdj[3:0], lowAdj};
        OP_DEC, OP_DSZ, OP_DSNZ: result_reg <= decRes;
        default: result_reg <= ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      squash_reg <= 1'b0;
    end else if (phase_reg == MCUIX_Q3) begin
      squash_reg <= skipNext;
    end
  end

  // Q4 write-back into the file; a clear or compare writes nothing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fileWr <= '0;
    end else begin
      fileWr.we <= 1'b0;
      fileWr.addr <= cur_reg.addr;
      fileWr.data <= result_reg;
      if (phase_reg == MCUIX_Q4) begin
        unique case (cur_reg.op)
          OP_COMPLEMENT_FILE_OP, OP_DEC, OP_DSZ, OP_DSNZ:
            fileWr.we <= cur_reg.dest;
          OP_DAJ: fileWr.we <= 1'b1;
          default: fileWr.we <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      workingAccumulator <= ZERO;
    end else if (phase_reg == MCUIX_Q4) begin
      unique case (cur_reg.op)
        OP_COMPLEMENT_FILE_OP, OP_DEC, OP_DSZ, OP_DSNZ: begin
          if (!cur_reg.dest) begin
            workingAccumulator <= result_reg;
          end
        end
        OP_DAJ: begin
          if (!cur_reg.dest) begin
            workingAccumulator <= result_reg;
          end
        end
        default: workingAccumulator <= workingAccumulator;
      endcase
    end
  end

  // Flags are taken at Q3 from the execute values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arithFlagsReg <= 4'h0;
    end else if (phase_reg == MCUIX_Q3) begin
      unique case (cur_reg.op)
        OP_COMPLEMENT_FILE_OP: arithFlagsReg[FLAG_Z] <= (~operand_reg == ZERO);
        OP_DAJ: arithFlagsReg[FLAG_C] <= highAdj[4] | highFix;
        OP_DEC: begin
          arithFlagsReg[FLAG_Z] <= (decRes == ZERO);
          arithFlagsReg[FLAG_C] <= ~decWide[DATA_W];
          arithFlagsReg[FLAG_DC] <= (operand_reg[3:0] != 4'h0);
          arithFlagsReg[FLAG_OV] <= operand_reg[7] & ~decRes[7];
        end
        default: arithFlagsReg <= arithFlagsReg;
      endcase
    end
  end

  // Watchdog state: the counter counts up at each Q4 here and is cleared by the clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      watchdogCounter <= WDOG_CLEAR;
      watchdogPostscaler <= 1'b0;
      timeoutFlag <= 1'b1;
      powerdownFlag <= 1'b1;
    end else if (phase_reg == MCUIX_Q3 && cur_reg.op == OP_WDCLR) begin
      watchdogCounter <= WDOG_CLEAR;
      watchdogPostscaler <= 1'b0;
      timeoutFlag <= 1'b1;
      powerdownFlag <= 1'b1;
    end else if (phase_reg == MCUIX_Q4) begin
      {watchdogPostscaler, watchdogCounter} <=
        {watchdogPostscaler, watchdogCounter} + 9'h001;
    end
  end

  // Program counter advances per cycle; jump replaces the low bits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      progCounter <= '0;
      programCounterHighLatch <= 8'h00;
    end else if (phase_reg == MCUIX_Q4) begin
      if (cur_reg.op == OP_JMP) begin
        progCounter <= {progCounter[PC_W-1:JUMP_W], cur_reg.lit};
        programCounterHighLatch <= {progCounter[PC_W-1:JUMP_W],
                                    cur_reg.lit[JUMP_W-1:8]};
      end else begin
        progCounter <= progCounter + 16'h0001;
      end
    end
  end

  AST_PHASE_CYCLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q1 |=> phase_reg == MCUIX_Q2 ##1
    phase_reg == MCUIX_Q3 ##1 phase_reg == MCUIX_Q4)
    else $error("phase order broken");
  AST_WDCLR_FLAGS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q3 && cur_reg.op == OP_WDCLR |=>
    watchdogCounter == WDOG_CLEAR && timeoutFlag && powerdownFlag)
    else $error("watchdog clear failed");
  AST_WDCLR_NOWR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q4 && cur_reg.op == OP_WDCLR |=> !fileWr.we)
    else $error("watchdog clear wrote file");
  // Flags move only on the Q3 edge, so stability is judged across it
  AST_CMP_NOSTORE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q3 && cur_reg.op == OP_CMPLT |=>
    $stable(arithFlagsReg) ##1 !fileWr.we)
    else $error("compare stored");
  AST_SKIP_NOP: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q3 && skipNext |=> ##2 cur_reg.op == OP_NONE)
    else $error("skip not squashed");
  AST_COMPLEMENT_FILE_OP_WR: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q4 && cur_reg.op == OP_COMPLEMENT_FILE_OP && cur_reg.dest |=>
    fileWr.we && fileWr.data == $past(result_reg))
    else $error("complement write missing");
  AST_DEST_ACC: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q4 && cur_reg.op == OP_DEC && !cur_reg.dest |=>
    !fileWr.we && workingAccumulator == $past(result_reg))
    else $error("accumulator destination wrong");
  AST_DAJ_FILE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q4 && cur_reg.op == OP_DAJ |=> fileWr.we)
    else $error("adjust result not in file");
  AST_DSNZ_FLAGS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q3 && cur_reg.op == OP_DSNZ |=>
    $stable(arithFlagsReg) && squash_reg == (decRes != ZERO))
    else $error("nonzero skip wrong");
  AST_JMP_PC: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    phase_reg == MCUIX_Q4 && cur_reg.op == OP_JMP |=>
    progCounter[JUMP_W-1:0] == $past(cur_reg.lit) && squash_reg)
    else $error("jump target wrong");

  COV_JMP: cover property (@(posedge ref_clk) cur_reg.op == OP_JMP);
  COV_SKIP: cover property (@(posedge ref_clk) squash_reg && skipNext == 0);
  COV_DAJ: cover property (@(posedge ref_clk) cur_reg.op == OP_DAJ && highFix);
endmodule

// ===== tb/mcuix_file_model.sv
// File register model facing the instruction executor
`timescale 1ns/1ps
module mcuix_file_model (
  input wire logic ref_clk,
  input wire logic [mcuix_pkg::ADDR_W-1:0] fileRdAddr,
  input wire mcuix_pkg::mcuix_wr_t fileWr,
  output logic [mcuix_pkg::DATA_W-1:0] fileRdData
);
  import mcuix_pkg::*;
  logic [DATA_W-1:0] mem [256];
  // Pattern fill, so no read ever hands back an unknown
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h5a ^ i[7:0];
    end
  end
  // Same-cycle read: the core samples it at the end of Q2
  assign fileRdData = mem[fileRdAddr];
  always @(posedge ref_clk) begin
    if (fileWr.we) begin
      mem[fileWr.addr] <= fileWr.data;
    end
  end
endmodule

// ===== tb/mcu_core_instr_subset_exec_tb.sv
// Testbench for the instruction subset executor
`timescale 1ns/1ps
module mcu_core_instr_subset_exec_tb;
  import mcuix_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic [15:0] instrWord;
  logic [7:0] fileRdData;
  logic [7:0] fileRdAddr;
  mcuix_wr_t fileWr;
  logic [15:0] progCounter;
  logic [7:0] pcLatch;
  logic [7:0] acc;
  logic [3:0] flags;
  logic timeoutFlag;
  logic powerdownFlag;
  logic [7:0] wdCount;
  logic wdPost;
  logic fetchStrobe;
  int fails;
  int samples_checked;
  logic [3:0] f;

  mcuix_core dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .instrWord(instrWord),
    .fileRdData(fileRdData),
    .fileRdAddr(fileRdAddr),
    .fileWr(fileWr),
    .progCounter(progCounter),
    .programCounterHighLatch(pcLatch),
    .workingAccumulator(acc),
    .arithFlagsReg(flags),
    .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag),
    .watchdogCounter(wdCount),
    .watchdogPostscaler(wdPost),
    .fetchStrobe(fetchStrobe)
  );

  mcuix_file_model mdl (
    .ref_clk(ref_clk),
    .fileRdAddr(fileRdAddr),
    .fileWr(fileWr),
    .fileRdData(fileRdData)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Words go in one take edge ahead; b is the word that a skip drops
  task automatic run(input logic [15:0] a, input logic [15:0] b);
    @(posedge ref_clk iff fetchStrobe) instrWord <= a;
    @(posedge ref_clk iff fetchStrobe) instrWord <= b;
    @(posedge ref_clk iff fetchStrobe) instrWord <= 16'h0000;
    @(posedge ref_clk iff fetchStrobe);
    @(posedge ref_clk);
    #1;
  endtask

  // No load-literal in the subset, so load through a complement
  task automatic setacc(input logic [7:0] v);
    mdl.mem[1] = ~v;
    run(16'h1201, 16'h0000);
  endtask

  // Decrement of a scratch byte sets carry unless v is zero, digit carry unless its low nibble is
  task automatic setflg(input logic [7:0] v);
    mdl.mem[8'h20] = v;
    run(16'h0720, 16'h0000);
  endtask

  task automatic t_cycle();
    int n;
    n = 0;
    @(posedge ref_clk iff fetchStrobe);
    do begin
      @(posedge ref_clk);
      n++;
    end while (!fetchStrobe);
    chk(n[7:0], 8'h04);
  endtask

  // Long idle first, so the postscaler is set before the clear
  task automatic t_wdclr();
    setacc(8'h77);
    mdl.mem[4] = 8'h11;
    repeat (1100) @(posedge ref_clk);
    run(16'h0004, 16'h0000);
    chk({6'h0, timeoutFlag, powerdownFlag}, 8'h03);
    chk({7'h0, wdCount < 8'h0a}, 8'h01);
    chk({7'h0, wdPost}, 8'h00);
    chk(acc, 8'h77);
    chk(mdl.mem[4], 8'h11);
  endtask

  task automatic t_comp();
    mdl.mem[10] = 8'h13;
    run(16'h120a, 16'h0000);
    chk(acc, 8'hec);
    chk(mdl.mem[10], 8'h13);
    chk({7'h0, flags[FLAG_Z]}, 8'h00);
    run(16'h130a, 16'h0000);
    chk(mdl.mem[10], 8'h13 ^ 8'hff);
    mdl.mem[10] = 8'hff;
    run(16'h130a, 16'h0000);
    chk(mdl.mem[10], 8'h00);
    chk({7'h0, flags[FLAG_Z]}, 8'h01);
  endtask

  task automatic t_cmp();
    setacc(8'h50);
    mdl.mem[2] = 8'h40;
    mdl.mem[3] = 8'h3c;
    f = flags;
    run(16'h3002, 16'h1203);
    chk(acc, 8'h50);
    chk({4'h0, flags}, {4'h0, f});
    chk(mdl.mem[2], 8'h40);
    mdl.mem[2] = 8'hf0;
    run(16'h3002, 16'h1203);
    chk(acc, 8'hc3);
  endtask

  task automatic t_dec();
    mdl.mem[8'h40] = 8'h10;
    run(16'h0640, 16'h0000);
    chk(acc, 8'h0f);
    chk({4'h0, flags}, 8'h01);
    mdl.mem[8'h40] = 8'h80;
    run(16'h0740, 16'h0000);
    chk(mdl.mem[8'h40], 8'h7f);
    chk({4'h0, flags}, 8'h09);
    mdl.mem[8'h40] = 8'h01;
    run(16'h0740, 16'h0000);
    chk(mdl.mem[8'h40], 8'h00);
    chk({4'h0, flags}, 8'h07);
  endtask

  task automatic t_daj();
    setflg(8'h00);
    setacc(8'ha5);
    run(16'h2e30, 16'h0000);
    chk(acc, 8'h05);
    chk(mdl.mem[8'h30], 8'h05);
    chk({7'h0, flags[FLAG_C]}, 8'h01);
    setacc(8'hce);
    run(16'h2e30, 16'h0000);
    chk(acc, 8'h24);
    setflg(8'h02);
    setacc(8'h23);
    run(16'h2f31, 16'h0000);
    chk(mdl.mem[8'h31], 8'h89);
    chk(acc, 8'h23);
    setflg(8'h00);
    setacc(8'h45);
    run(16'h2e32, 16'h0000);
    chk(acc, 8'h45);
    chk({7'h0, flags[FLAG_C]}, 8'h00);
  endtask

  // Skip forms: s makes the skip taken, u leaves it untaken
  task automatic t_dskip(input logic [15:0] op, input logic [7:0] s,
                         input logic [7:0] u);
    setacc(8'h11);
    mdl.mem[8'h40] = s;
    f = flags;
    run(op, 16'h1203);
    chk(mdl.mem[8'h40], s - 8'h01);
    chk(acc, 8'h11);
    chk({4'h0, flags}, {4'h0, f});
    mdl.mem[8'h40] = u;
    run(op, 16'h1203);
    chk(mdl.mem[8'h40], u - 8'h01);
    chk(acc, 8'hc3);
  endtask

  // The forced no-op cycle still advances the counter once
  task automatic t_jmp();
    setacc(8'h11);
    run(16'hda40, 16'h1203);
    chk(pcLatch, 8'h1a);
    chk({3'h0, progCounter[12:8]}, 8'h1a);
    chk(progCounter[7:0], 8'h41);
    chk(acc, 8'h11);
  endtask

  task automatic results();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    instrWord = 16'h0000;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_cycle();
    t_wdclr();
    t_comp();
    t_cmp();
    t_dec();
    t_daj();
    t_dskip(16'h1740, 8'h01, 8'h02);
    t_dskip(16'h2740, 8'h05, 8'h01);
    t_jmp();
    results();
  end

  // Whole sequence needs about sixteen hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    results();
  end
endmodule
